/* sep_core.sv */
// Protocol, hold, write-latch and protection front-end of a serial EEPROM.
`timescale 1ns/1ps
`default_nettype none
module sep_core
  import sep_pkg::*;
#(
  parameter int TW_CYCLES = TW_CYC
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  input  wire logic              sck_i,
  input  wire logic              cs_b_i,
  input  wire logic              sdi_i,
  input  wire logic              hold_b_i,
  input  wire logic              wp_b_i,
  input  wire logic [2:0]        nv_status_i,
  input  wire logic [7:0]        rd_data_i,
  input  wire logic              stg_ready_i,
  output logic                   sdo_o,
  output logic                   sdo_oe_o,
  output logic                   status_lock_o,
  output logic                   protect_size_hi_o,
  output logic                   protect_size_lo_o,
  output logic                   write_enable_latch_o,
  output logic                   write_in_progress_o,
  output logic                   active_o,
  output logic                   standby_o,
  output logic [MEM_AW-1:0]      rd_addr_o,
  output logic                   stg_valid_o,
  output logic [STG_W-1:0]       stg_word_o,
  output logic                   wr_commit_o,
  output logic                   wr_abort_o
);
  logic [4:0] sy1_reg, sy2_reg, sy3_reg;
  logic       sck_s, cs_s, si_s, hold_s, wp_s;
  logic       sck_rise, sck_fall, cs_fall, cs_rise, hold_fall, hold_rise;
  sep_state_t st_reg, st_next;
  logic [7:0] opc_reg, opc_next, sh_reg, sh_next, out_reg, out_next;
  logic [2:0] bit_reg, bit_next, obit_reg, obit_next;
  logic       abyte_reg, abyte_next, extra_reg, extra_next, hold_reg, hold_next;
  logic [MEM_AW-1:0] addr_reg, addr_next, raddr_reg, raddr_next;
  logic       wel_reg, wel_next, wip_reg, wip_next;
  logic [2:0] nv_reg, nv_next, nvs_reg, nvs_next;
  logic       nvw_reg, nvw_next, init_reg;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic       so_reg, so_next, oe_reg, oe_next, cm_reg, cm_next, ab_reg, ab_next;
  logic       push, sck_r, sck_f;
  logic [7:0] byte_in, src;
  logic [1:0] v_reg, v_next;
  logic [STG_W-1:0] e0_reg, e0_next, e1_reg, e1_next;

  // Pins pass two flip-flops; the third stage only feeds edge detection.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      sy1_reg <= 5'h18;
      sy2_reg <= 5'h18;
      sy3_reg <= 5'h18;
    end
    else
    begin
      sy1_reg <= {wp_b_i, hold_b_i, sdi_i, cs_b_i, sck_i};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  assign sck_s     = sy2_reg[0];
  assign cs_s      = sy2_reg[1];
  assign si_s      = sy2_reg[2];
  assign hold_s    = sy2_reg[3];
  assign wp_s      = sy2_reg[4];
  assign sck_rise  = sck_s & ~sy3_reg[0];
  assign sck_fall  = ~sck_s & sy3_reg[0];
  assign cs_fall   = ~cs_s & sy3_reg[1];
  assign cs_rise   = cs_s & ~sy3_reg[1];
  assign hold_fall = ~hold_s & sy3_reg[3];
  assign hold_rise = hold_s & ~sy3_reg[3];
  assign sck_r     = sck_rise & ~hold_reg;
  assign sck_f     = sck_fall & ~hold_reg;
  assign byte_in   = {sh_reg[6:0], si_s};
  assign src       = (opc_reg == OPC_ST_RD) ?
                     {nv_reg[2], 3'h0, nv_reg[1:0], wel_reg, wip_reg} : rd_data_i;

  function automatic logic is_prot(input logic [1:0] sz, input logic [MEM_AW-1:0] a);
    case (sz)
      PROT_NONE:  is_prot = 1'b0;
      PROT_QUART: is_prot = &a[MEM_AW-1:MEM_AW-2];
      PROT_HALF:  is_prot = a[MEM_AW-1];
      default:    is_prot = 1'b1;
    endcase
  endfunction : is_prot

  // Array-write bytes enter the staging buffer unless protected, unarmed, busy or the buffer is full.
  assign push = sck_r && st_reg == ST_DATA && opc_reg == OPC_ARR_WR && bit_reg == 3'h7
                && wel_reg && !wip_reg && !is_prot(nv_reg[1:0], addr_reg)
                && !v_reg[1];

  always_comb
  begin
    st_next    = st_reg;
    opc_next   = opc_reg;
    sh_next    = sh_reg;
    out_next   = out_reg;
    bit_next   = bit_reg;
    obit_next  = obit_reg;
    abyte_next = abyte_reg;
    extra_next = extra_reg;
    hold_next  = hold_reg;
    addr_next  = addr_reg;
    raddr_next = raddr_reg;
    wel_next   = wel_reg;
    wip_next   = wip_reg;
    nv_next    = nv_reg;
    nvs_next   = nvs_reg;
    nvw_next   = nvw_reg;
    tmr_next   = tmr_reg;
    so_next    = so_reg;
    cm_next    = 1'b0;
    ab_next    = 1'b0;
    if (wip_reg)
    begin
      if (tmr_reg == '0)
      begin
        wip_next = 1'b0;
        wel_next = 1'b0;
        if (nvw_reg)
          nv_next = nvs_reg;
        nvw_next = 1'b0;
      end
      else
        tmr_next = tmr_reg - 1'b1;
    end
    // Hold toggles on its input edges with the clock low, and clears when deselected or idle.
    if (st_reg == ST_IDLE || cs_s)
      hold_next = 1'b0;
    else if (!hold_reg && hold_fall && !sck_s)
      hold_next = 1'b1;
    else if (hold_reg && hold_rise && !sck_s)
      hold_next = 1'b0;
    if (cs_rise && st_reg != ST_IDLE)
    begin
      st_next = ST_IDLE;
      if (hold_reg)
        ab_next = (opc_reg == OPC_ARR_WR);
      else if (st_reg == ST_WAIT && bit_reg == 3'h0 && !extra_reg)
      begin
        if (opc_reg == OPC_ARM)
          wel_next = 1'b1;
        else if (opc_reg == OPC_DISARM)
          wel_next = 1'b0;
        else if (opc_reg == OPC_ST_WR && wel_reg && !wip_reg
                 && !(nv_reg[2] && !wp_s))
        begin
          nvs_next = {sh_reg[ST_LOCK_BIT], sh_reg[ST_HI_BIT], sh_reg[ST_LO_BIT]};
          nvw_next = 1'b1;
          wip_next = 1'b1;
          tmr_next = TMR_W'(TW_CYCLES - 1);
        end
      end
      else if (opc_reg == OPC_ARR_WR && st_reg == ST_DATA)
      begin
        if (bit_reg == 3'h0 && extra_reg && wel_reg && !wip_reg)
        begin
          cm_next  = 1'b1;
          wip_next = 1'b1;
          tmr_next = TMR_W'(TW_CYCLES - 1);
        end
        else
          ab_next = 1'b1;
      end
      else if (opc_reg == OPC_ARR_WR)
        ab_next = 1'b1;
    end
    else if (cs_fall && st_reg == ST_IDLE)
    begin
      st_next    = ST_OPC;
      bit_next   = 3'h0;
      obit_next  = 3'h0;
      abyte_next = 1'b0;
      extra_next = 1'b0;
    end
    else if (sck_r && st_reg != ST_IDLE && st_reg != ST_IGN)
    begin
      sh_next  = byte_in;
      bit_next = bit_reg + 3'h1;
      if (bit_reg == 3'h7)
      begin
        case (st_reg)
          ST_OPC:
          begin
            opc_next = byte_in;
            case (byte_in)
              OPC_ARM, OPC_DISARM:   st_next = ST_WAIT;
              OPC_ST_WR:             st_next = ST_DATA;
              OPC_ST_RD:             st_next = ST_RD;
              OPC_ARR_RD, OPC_ARR_WR: st_next = ST_ADDR;
              default:               st_next = ST_IGN;
            endcase
          end
          ST_ADDR:
          begin
            abyte_next = 1'b1;
            if (abyte_reg)
            begin
              addr_next  = {addr_reg[MEM_AW-9:0], byte_in};
              raddr_next = {addr_reg[MEM_AW-9:0], byte_in};
              st_next    = (opc_reg == OPC_ARR_RD) ? ST_RD : ST_DATA;
            end
            else
              addr_next[MEM_AW-9:0] = byte_in[MEM_AW-9:0];
          end
          ST_DATA:
          begin
            if (opc_reg == OPC_ST_WR)
              st_next = ST_WAIT;
            else
            begin
              extra_next = 1'b1;
              addr_next  = addr_reg + 1'b1;
            end
          end
          ST_WAIT:   extra_next = 1'b1;
          default:   st_next = st_reg;
        endcase
      end
      else if (st_reg == ST_WAIT)
        extra_next = 1'b1;
    end
    // Read data leaves on falling clock edges, most significant bit first.
    if (sck_f && st_reg == ST_RD && !cs_s)
    begin
      obit_next = obit_reg + 3'h1;
      if (obit_reg == 3'h0)
      begin
        so_next  = src[7];
        out_next = {src[6:0], 1'b0};
      end
      else
      begin
        so_next  = out_reg[7];
        out_next = {out_reg[6:0], 1'b0};
      end
      if (obit_reg == 3'h7 && opc_reg == OPC_ARR_RD)
        raddr_next = raddr_reg + 1'b1;
    end
  end

  assign oe_next = (st_reg == ST_RD) && !cs_s && !hold_reg && obit_reg != 3'h0
                   || (oe_reg && st_reg == ST_RD && !cs_s && !hold_reg);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      st_reg    <= ST_IDLE;
      opc_reg   <= 8'h00;
      sh_reg    <= 8'h00;
      out_reg   <= 8'h00;
      bit_reg   <= 3'h0;
      obit_reg  <= 3'h0;
      abyte_reg <= 1'b0;
      extra_reg <= 1'b0;
      hold_reg  <= 1'b0;
      addr_reg  <= '0;
      raddr_reg <= '0;
      wel_reg   <= 1'b0;
      wip_reg   <= 1'b0;
      nvs_reg   <= 3'h0;
      nvw_reg   <= 1'b0;
      tmr_reg   <= '0;
      so_reg    <= 1'b0;
      oe_reg    <= 1'b0;
      cm_reg    <= 1'b0;
      ab_reg    <= 1'b0;
      init_reg  <= 1'b1;
    end
    else
    begin
      st_reg    <= st_next;
      opc_reg   <= opc_next;
      sh_reg    <= sh_next;
      out_reg   <= out_next;
      bit_reg   <= bit_next;
      obit_reg  <= obit_next;
      abyte_reg <= abyte_next;
      extra_reg <= extra_next;
      hold_reg  <= hold_next;
      addr_reg  <= addr_next;
      raddr_reg <= raddr_next;
      wel_reg   <= wel_next;
      wip_reg   <= wip_next;
      nvs_reg   <= nvs_next;
      nvw_reg   <= nvw_next;
      tmr_reg   <= tmr_next;
      so_reg    <= so_next;
      oe_reg    <= oe_next;
      cm_reg    <= cm_next;
      ab_reg    <= ab_next;
      init_reg  <= 1'b0;
    end
  end

  // Non-volatile bits are reloaded from the store while reset is held.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || init_reg)
      nv_reg <= nv_status_i;
    else
      nv_reg <= nv_next;
  end

  // Two-entry staging buffer; entry 0 is always the head.
  always_comb
  begin
    v_next  = v_reg;
    e0_next = e0_reg;
    e1_next = e1_reg;
    if (v_reg[0] && stg_ready_i)
    begin
      e0_next = e1_reg;
      v_next  = {1'b0, v_reg[1]};
    end
    if (push)
    begin
      if (!v_next[0])
      begin
        e0_next    = {addr_reg, byte_in};
        v_next[0]  = 1'b1;
      end
      else
      begin
        e1_next    = {addr_reg, byte_in};
        v_next[1]  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      v_reg  <= 2'h0;
      e0_reg <= '0;
      e1_reg <= '0;
    end
    else
    begin
      v_reg  <= v_next;
      e0_reg <= e0_next;
      e1_reg <= e1_next;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      active_o  <= 1'b0;
      standby_o <= 1'b1;
    end
    else
    begin
      active_o  <= (st_next != ST_IDLE);
      standby_o <= (st_next == ST_IDLE) && !wip_next;
    end
  end

  assign sdo_o                = so_reg;
  assign sdo_oe_o             = oe_reg;
  assign status_lock_o        = nv_reg[2];
  assign protect_size_hi_o    = nv_reg[1];
  assign protect_size_lo_o    = nv_reg[0];
  assign write_enable_latch_o = wel_reg;
  assign write_in_progress_o  = wip_reg;
  assign rd_addr_o            = raddr_reg;
  assign stg_valid_o          = v_reg[0];
  assign stg_word_o           = e0_reg;
  assign wr_commit_o          = cm_reg;
  assign wr_abort_o           = ab_reg;
endmodule : sep_core
`default_nettype wire

/* sep_core_props.sv */
// Concurrent checks on the ports of the serial EEPROM front-end.
`timescale 1ns/1ps
`default_nettype none
module sep_core_props
  import sep_pkg::*;
#(
  parameter int TW_CYCLES = TW_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic hold_b_i,
  input wire logic sdo_oe_o,
  input wire logic status_lock_o,
  input wire logic protect_size_hi_o,
  input wire logic protect_size_lo_o,
  input wire logic write_enable_latch_o,
  input wire logic write_in_progress_o,
  input wire logic active_o,
  input wire logic standby_o,
  input wire logic wr_commit_o,
  input wire logic wr_abort_o
);
  logic [TMR_W-1:0] busy_cnt_reg;
  logic [TMR_W-1:0] busy_cnt_next;
  always_comb busy_cnt_next = write_in_progress_o ? busy_cnt_reg + 1'b1 : '0;
  always_ff @(posedge clk_sys_i) busy_cnt_reg <= busy_cnt_next;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  reset_state_a: assert property (
    $rose(rst_b_i) |-> standby_o && !active_o && !write_enable_latch_o && !write_in_progress_o)
    else $error("state after reset wrong");
  busy_standby_a: assert property (
    write_in_progress_o [*2] |-> !standby_o) else $error("standby while busy");
  arm_on_cs_a: assert property (
    $rose(write_enable_latch_o) |-> cs_b_i && $past(cs_b_i, 2)) else $error("latch set early");
  busy_needs_wel_a: assert property (
    $rose(write_in_progress_o) |-> $past(write_enable_latch_o) && cs_b_i)
    else $error("write cycle without latch");
  busy_len_a: assert property (
    $fell(write_in_progress_o) |-> busy_cnt_reg >= TW_CYCLES - 1 && busy_cnt_reg <= TW_CYCLES + 2)
    else $error("write cycle length wrong");
  wel_clear_a: assert property (
    $fell(write_in_progress_o) |-> ##[0:2] !write_enable_latch_o) else $error("latch not cleared");
  deselect_a: assert property (
    cs_b_i [*6] |-> !active_o && !sdo_oe_o) else $error("active while deselected");
  hold_float_a: assert property (
    !hold_b_i [*6] |-> !sdo_oe_o) else $error("output driven in hold");
  commit_pulse_a: assert property (
    wr_commit_o |-> cs_b_i && !wr_abort_o ##1 !wr_commit_o) else $error("commit pulse wrong");
  nv_steady_a: assert property (
    $changed({status_lock_o, protect_size_hi_o, protect_size_lo_o}) && $past(rst_b_i, 3)
    |-> !write_in_progress_o && ($past(write_in_progress_o) || $past(write_in_progress_o, 2)))
    else $error("protection bits changed outside a write cycle");
  cover property ($rose(write_in_progress_o));
  cover property (wr_commit_o);
  cover property (!hold_b_i [*6]);
endmodule : sep_core_props
`default_nettype wire

/* sep_pkg.sv */
// Constants shared by the serial EEPROM protocol front-end.
package sep_pkg;
  localparam logic [7:0] OPC_ARM     = 8'h06;
  localparam logic [7:0] OPC_DISARM  = 8'h04;
  localparam logic [7:0] OPC_ST_RD   = 8'h05;
  localparam logic [7:0] OPC_ST_WR   = 8'h01;
  localparam logic [7:0] OPC_ARR_RD  = 8'h03;
  localparam logic [7:0] OPC_ARR_WR  = 8'h02;
  localparam int         MEM_AW      = 11;
  localparam int         STG_W       = MEM_AW + 8;
  localparam logic [1:0] PROT_NONE   = 2'h0;
  localparam logic [1:0] PROT_QUART  = 2'h1;
  localparam logic [1:0] PROT_HALF   = 2'h2;
  localparam int         ST_LOCK_BIT = 7;
  localparam int         ST_HI_BIT   = 3;
  localparam int         ST_LO_BIT   = 2;
  localparam int         ST_WEL_BIT  = 1;
  localparam int         ST_WIP_BIT  = 0;
  localparam int         CLK_HZ      = 25000000;
  localparam int         TW_US       = 5000;
  localparam int         TW_CYC      = TW_US * (CLK_HZ / 1000000);
  localparam int         TMR_W       = 24;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_RD   = 3'b100,
    ST_WAIT = 3'b101,
    ST_IGN  = 3'b110
  } sep_state_t;
endpackage : sep_pkg

/* sep_spi_master.sv */
// Bus master model driving the serial pins of the EEPROM front-end.
`timescale 1ns/1ps
`default_nettype none
module sep_spi_master (
  input  wire logic clk_sys_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output var logic  sck_o    = 1'b0,
  output var logic  cs_b_o   = 1'b0,
  output var logic  sdi_o    = 1'b0,
  output var logic  hold_b_o = 1'b1
);
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : tick
  task automatic start();
    cs_b_o = 1'b0;
    tick(4);
  endtask : start
  task automatic clk_bit(input logic b);
    sdi_o = b;
    tick(4);
    sck_o = 1'b1;
    tick(4);
    sck_o = 1'b0;
  endtask : clk_bit
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) clk_bit(b[i]);
  endtask : send
  task automatic recv(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      tick(4);
      sck_o = 1'b1;
      tick(4);
      b[i] = sdo_oe_i ? sdo_i : 1'bx;
      sck_o = 1'b0;
    end
  endtask : recv
  task automatic stop();
    tick(2);
    cs_b_o = 1'b1;
    sdi_o = ~sdi_o;
    tick(12);
  endtask : stop
  task automatic hold(input logic on);
    hold_b_o = ~on;
    tick(4);
  endtask : hold
endmodule : sep_spi_master
`default_nettype wire

/* tb.sv */
// Self-checking bench for the serial EEPROM protocol front-end.
`timescale 1ns/1ps
`default_nettype none
module tb
  import sep_pkg::*;
;
  logic clk_sys_i, rst_b_i, wp_b_i, stg_ready_i, sck_i, cs_b_i, sdi_i, hold_b_i;
  logic [2:0] nv_status_i;
  logic [7:0] rd_data_i;
  logic [7:0] rd_byte;
  logic sdo_o, sdo_oe_o, status_lock_o, protect_size_hi_o, protect_size_lo_o;
  logic write_enable_latch_o, write_in_progress_o, active_o, standby_o;
  logic stg_valid_o, wr_commit_o, wr_abort_o;
  logic [MEM_AW-1:0] rd_addr_o;
  logic [STG_W-1:0] stg_word_o;
  logic [STG_W-1:0] exp_q[$];
  int err_count = 0;
  int n_tests = 0;
  int n_commit = 0;
  int n_abort = 0;
  int c0;
  // Array model: each byte holds its low address bits mixed with a fixed pattern.
  assign rd_data_i = rd_addr_o[7:0] ^ 8'h3C;
  sep_core #(.TW_CYCLES(20)) uut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sck_i(sck_i), .cs_b_i(cs_b_i),
    .sdi_i(sdi_i), .hold_b_i(hold_b_i), .wp_b_i(wp_b_i), .nv_status_i(nv_status_i),
    .rd_data_i(rd_data_i), .stg_ready_i(stg_ready_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .status_lock_o(status_lock_o), .protect_size_hi_o(protect_size_hi_o),
    .protect_size_lo_o(protect_size_lo_o), .write_enable_latch_o(write_enable_latch_o),
    .write_in_progress_o(write_in_progress_o), .active_o(active_o), .standby_o(standby_o),
    .rd_addr_o(rd_addr_o), .stg_valid_o(stg_valid_o), .stg_word_o(stg_word_o),
    .wr_commit_o(wr_commit_o), .wr_abort_o(wr_abort_o));
  sep_spi_master m (.clk_sys_i(clk_sys_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .sck_o(sck_i),
    .cs_b_o(cs_b_i), .sdi_o(sdi_i), .hold_b_o(hold_b_i));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [STG_W-1:0] got, input logic [STG_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op);
    m.start();
    m.send(op);
    m.stop();
  endtask : cmd
  task automatic wrst(input logic [7:0] d);
    m.start();
    m.send(OPC_ST_WR);
    m.send(d);
    m.stop();
  endtask : wrst
  task automatic wait_idle();
    int i;
    i = 0;
    while (write_in_progress_o !== 1'b0)
    begin
      m.tick(1);
      i++;
      if (i > 400)
      begin
        err_count++;
        $display("mismatch at %0t: write cycle never ended", $time);
        report_and_stop();
      end
    end
  endtask : wait_idle
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    if (stg_valid_o === 1'b1 && stg_ready_i === 1'b1)
      check(stg_word_o, exp_q.pop_front());
    if (wr_commit_o === 1'b1)
      n_commit++;
    if (wr_abort_o === 1'b1)
      n_abort++;
  end
  initial
  begin
    rst_b_i = 1'b0;
    wp_b_i = 1'b1;
    stg_ready_i = 1'b0;
    nv_status_i = 3'h0;
    repeat (5) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    m.tick(1);
    check(active_o, 1'b0);
    m.send(OPC_ARM);
    m.stop();
    check(write_enable_latch_o, 1'b0);
    m.start();
    m.send(OPC_ARM);
    m.tick(8);
    check(write_enable_latch_o, 1'b0);
    m.stop();
    check(write_enable_latch_o, 1'b1);
    cmd(OPC_DISARM);
    check(write_enable_latch_o, 1'b0);
    wrst(8'h0C);
    check(write_in_progress_o, 1'b0);
    cmd(OPC_ARM);
    m.start();
    m.send(OPC_ST_WR);
    m.send(8'h0C);
    m.clk_bit(1'b0);
    m.stop();
    check({write_in_progress_o, write_enable_latch_o}, 2'h1);
    m.start();
    m.send(OPC_ST_WR);
    m.send(8'h0C);
    m.hold(1'b1);
    m.stop();
    m.hold(1'b0);
    check(write_in_progress_o, 1'b0);
    cmd(OPC_ARM);
    m.start();
    m.send(OPC_ST_WR);
    m.hold(1'b1);
    m.clk_bit(1'b1);
    m.clk_bit(1'b1);
    m.hold(1'b0);
    m.send(8'h0C);
    m.stop();
    check(write_in_progress_o, 1'b1);
    wait_idle();
    check({protect_size_hi_o, protect_size_lo_o, write_enable_latch_o}, 3'h6);
    m.start();
    m.send(OPC_ST_RD);
    m.recv(rd_byte);
    m.stop();
    check(rd_byte, 8'h0C);
    m.start();
    m.send(8'hFF);
    m.send(OPC_ARM);
    m.stop();
    check(write_enable_latch_o, 1'b0);
    cmd(OPC_ARM);
    m.start();
    m.send(OPC_ARR_WR);
    m.send(8'h00);
    m.send(8'h10);
    m.send(8'h5A);
    m.stop();
    check(stg_valid_o, 1'b0);
    wait_idle();
    cmd(OPC_ARM);
    wrst(8'h04);
    wait_idle();
    check({protect_size_hi_o, protect_size_lo_o}, 2'h1);
    cmd(OPC_ARM);
    c0 = n_commit;
    exp_q.push_back({11'h5FE, 8'h11});
    exp_q.push_back({11'h5FF, 8'h22});
    m.start();
    m.send(OPC_ARR_WR);
    m.send(8'h05);
    m.send(8'hFE);
    m.send(8'h11);
    m.send(8'h22);
    m.send(8'h33);
    check(stg_valid_o, 1'b1);
    m.stop();
    stg_ready_i = 1'b1;
    wait_idle();
    check(exp_q.size(), 0);
    check(n_commit - c0, 1);
    c0 = n_abort;
    cmd(OPC_ARM);
    m.start();
    m.send(OPC_ARR_WR);
    m.send(8'h00);
    m.send(8'h20);
    m.clk_bit(1'b1);
    m.stop();
    check(n_abort - c0, 1);
    check({write_in_progress_o, write_enable_latch_o}, 2'h1);
    cmd(OPC_ARM);
    wrst(8'h84);
    wait_idle();
    check(status_lock_o, 1'b1);
    wp_b_i = 1'b0;
    cmd(OPC_ARM);
    wrst(8'h00);
    check({write_in_progress_o, status_lock_o, protect_size_lo_o}, 3'h3);
    check(write_enable_latch_o, 1'b1);
    m.start();
    m.send(OPC_ARR_RD);
    m.send(8'h01);
    m.send(8'h23);
    m.recv(rd_byte);
    check(rd_byte, 8'h1F);
    m.hold(1'b1);
    m.tick(4);
    check(sdo_oe_o, 1'b0);
    m.hold(1'b0);
    m.recv(rd_byte);
    m.stop();
    check(rd_byte, 8'h18);
    check(rd_addr_o, 11'h125);
    nv_status_i = 3'h2;
    rst_b_i = 1'b0;
    m.tick(5);
    rst_b_i = 1'b1;
    m.tick(2);
    check({status_lock_o, protect_size_hi_o, protect_size_lo_o}, 3'h2);
    check({write_enable_latch_o, active_o, standby_o}, 3'h1);
    report_and_stop();
  end
endmodule : tb
bind sep_core sep_core_props #(.TW_CYCLES(TW_CYCLES)) chk_i (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .hold_b_i(hold_b_i), .sdo_oe_o(sdo_oe_o),
  .status_lock_o(status_lock_o), .protect_size_hi_o(protect_size_hi_o),
  .protect_size_lo_o(protect_size_lo_o), .write_enable_latch_o(write_enable_latch_o),
  .write_in_progress_o(write_in_progress_o), .active_o(active_o), .standby_o(standby_o),
  .wr_commit_o(wr_commit_o), .wr_abort_o(wr_abort_o));
`default_nettype wire
